// ===== bench/encoder_process_data_and_safety_params_bench.sv
// Self-checking bench for the encoder process image block
module encoder_process_data_and_safety_params_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, dir_cfg = 1'b1, par_wr, par_commit, tele_ok, refused, safe;
    logic [27:0] base = '0, acc = '0, step = '0;
    logic [7:0]  img_byte, par_data;
    logic [15:0] wd_time;
    logic [2:0]  img_ofs = 3'h4;
    logic [3:0]  par_ofs;
    encoder_image_pkg::input_image_s image;
    int err_count = 0, checked = 0, cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    // Ramp moves at negedge so the design samples a settled position
    always @(negedge ref_clk) acc <= acc + step;
    always @(posedge ref_clk) if (++cycles == 5000) report_and_stop(1);
    encoder_process_image #(.BASE_CYC(10), .MS_CYC(4)) encoder_process_image_inst (.ref_clk,
        .rst_n, .raw_pos(base + acc), .dir_cfg, .integ_set(7'h02), .station_pins(7'h03),
        .img_ofs, .img_byte_ff(img_byte), .image_ff(image), .par_wr, .par_ofs, .par_data,
        .par_commit, .tele_ok, .par_refused_ff(refused), .wd_time_ff(wd_time),
        .safe_state_ff(safe));
    safety_host_model safety_host_model_inst (.ref_clk, .par_wr, .par_ofs, .par_data,
        .par_commit, .tele_ok);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop(input int extra);
        err_count += extra;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic flags(input logic [15:0] exp);
        repeat (3) @(negedge ref_clk);
        check({14'h0, refused, safe}, exp);
    endtask
    task automatic image_test();
        base = {15'h5a5b, 13'h1abc};
        repeat (2) @(negedge ref_clk);
        check(image.multi, 16'h5a5b);
        check(image.single, 16'h1abc);
        check({8'h00, img_byte}, 16'h005a);
        img_ofs = 3'h7;
        @(negedge ref_clk);
        check({8'h00, img_byte}, 16'h00bc);
    endtask
    // Several periods of 20 cycles pass, so one full period follows any change
    task automatic speed_step(input logic d, input logic [27:0] k, input logic [15:0] v, s);
        {dir_cfg, step} = {d, k};
        repeat (70) @(negedge ref_clk);
        check(image.speed, v);
        check(image.status, s);
        img_ofs = 3'h2;
        @(negedge ref_clk);
        check({8'h00, img_byte}, {8'h00, v[15:8]});
        img_ofs = 3'h3;
        @(negedge ref_clk);
        check({8'h00, img_byte}, {8'h00, v[7:0]});
    endtask
    task automatic param_test();
        safety_host_model_inst.send({8'h08, 8'h48, 16'h1, 16'h1f7, 16'h7e, 48'h0});
        safety_host_model_inst.tele();
        flags(16'h0000);
        check(wd_time, 16'h007e);
        repeat (467) @(negedge ref_clk);
        flags(16'h0000);
        repeat (37) @(negedge ref_clk);
        flags(16'h0001);
        safety_host_model_inst.send({8'h09, 8'h48, 16'h1, 16'h1f7, 16'h7e, 48'h0});
        flags(16'h0003);
        safety_host_model_inst.send({8'h08, 8'h48, 16'h1, 16'h1f7, 16'h7e, 48'h0});
        flags(16'h0001);
        safety_host_model_inst.send({8'h08, 8'h48, 16'h1, 16'h1f8, 16'h7d, 48'h0});
        safety_host_model_inst.tele();
        flags(16'h0003);
    endtask
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        flags(16'h0001);
        image_test();
        speed_step(1'b1, 28'h3, 16'h003c, 16'h0000);
        speed_step(1'b0, 28'h3, 16'hffc4, 16'h0000);
        speed_step(1'b1, 28'h7d0, 16'h7fff, 16'h0001);
        speed_step(1'b0, 28'h7d0, 16'h8000, 16'h0001);
        speed_step(1'b1, 28'h3, 16'h003c, 16'h0000);
        param_test();
        report_and_stop(0);
    end
endmodule // encoder_process_data_and_safety_params_bench

// ===== bench/safety_host_model.sv
// Safety host model: streams parameter blocks and pulses telegrams
module safety_host_model (
    input  wire logic       ref_clk,    // Clock
    output logic            par_wr,     // Byte strobe
    output logic      [3:0] par_ofs,    // Offset
    output logic      [7:0] par_data,   // Byte
    output logic            par_commit, // Commit
    output logic            tele_ok     // Telegram
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {par_wr, par_ofs, par_data, par_commit, tele_ok} = '0;
    // Big-endian bytes, checksums as given; data inverted once released
    task automatic send(input encoder_image_pkg::param_block_s b);
        for (int i = 0; i < 14; i++) begin
            @(negedge ref_clk);
            {par_wr, par_ofs, par_data} = {1'b1, 4'(i), b[111-8*i -: 8]};
        end
        @(negedge ref_clk);
        {par_wr, par_data, par_commit} = {1'b0, ~par_data, 1'b1};
        @(negedge ref_clk);
        par_commit = 1'b0;
    endtask
    task automatic tele();
        @(negedge ref_clk);
        tele_ok = 1'b1;
        @(negedge ref_clk);
        tele_ok = 1'b0;
    endtask
endmodule // safety_host_model

// ===== rtl/encoder_image_pkg.sv
// Constants, types and field layouts for the encoder cyclic image and safety parameter block
//
// Operation
// - Status word bit 0 flags speed outside the signed 16-bit range.
// - Speed is reported as a signed two's complement 16-bit word.
// - Forward gives positive clockwise speed; backward gives negative speed.
// - Overflowed speed saturates at +32767 or -32768 until back in range.
// - The overflow flag clears by itself once speed is back in range.
// - Speed is position increments counted over one integration period.
// - Integration period is a setting of 1 to 100 times 5 ms.
// - Image words at offsets 0, 2, 4, 6, each high byte first.
// - Single-turn word carries the 13-bit step within one revolution.
// - Position equals revolutions times 8192 plus steps; revolutions span 0 to 32767.
// - Multi-turn and single-turn words are unsigned, without sign bit.
// - Direction bit 0 counts down clockwise; 1, the default, counts up.
// - Decode integrity class bits 3-2 and compare with local capability.
// - Sequence check option bit 0 is fixed at zero, no check.
// - CRC length bits 5-4 of byte 0 must be 00.
// - Block identifier bits 5-3 of byte 1 must be 001.
// - Protocol version bits 7-6 of byte 1 must be 01.
// - Destination address must equal station address plus 500, within 501 to 599.
// - Without a valid telegram within watchdog time the device goes safe.
// - Parameter fields are big-endian at offsets 2, 4, 6, 8 and 12.
// - The 32-bit device parameter checksum is supplied by the host.
// - The 16-bit parameter checksum is supplied with the parameter block.
package encoder_image_pkg;

    // ------------------------------------------------------------------
    // Input image layout
    // ------------------------------------------------------------------
    localparam logic [2:0]  STATUS_OFS   = 3'h0;
    localparam logic [2:0]  SPEED_OFS    = 3'h2;
    localparam logic [2:0]  MULTI_OFS    = 3'h4;
    localparam logic [2:0]  SINGLE_OFS   = 3'h6;
    localparam int          OVF_BIT      = 0;
    localparam int          STEP_BITS    = 13;
    localparam int          TURN_BITS    = 15;
    localparam int          POS_BITS     = STEP_BITS + TURN_BITS;
    localparam logic [15:0] SPEED_POS_SAT = 16'h7fff;
    localparam logic [15:0] SPEED_NEG_SAT = 16'h8000;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ       = 200_000_000;
    localparam int          MS_CYCLES    = CLK_HZ / 1000;
    localparam int          BASE_MS      = 5;
    localparam int          BASE_CYCLES  = BASE_MS * MS_CYCLES;
    localparam logic [6:0]  INTEG_MIN    = 7'h01;
    localparam logic [6:0]  INTEG_MAX    = 7'h64;
    localparam logic        DIR_RST      = 1'b1;

    // ------------------------------------------------------------------
    // Safety parameter block layout and fixed values
    // ------------------------------------------------------------------
    localparam int          PAR_BYTES    = 14;
    localparam int          SEQ_BIT      = 0;
    localparam int          CLASS_LSB    = 2;
    localparam int          CRCLEN_LSB   = 4;
    localparam int          BLKID_LSB    = 3;
    localparam int          VER_LSB      = 6;
    localparam int          SRC_OFS      = 2;
    localparam int          DEST_OFS     = 4;
    localparam int          WD_OFS       = 6;
    localparam int          IPAR_OFS     = 8;
    localparam int          PCRC_OFS     = 12;
    localparam logic [1:0]  CRCLEN_REQ   = 2'h0;
    localparam logic [2:0]  BLKID_REQ    = 3'h1;
    localparam logic [1:0]  VER_REQ      = 2'h1;
    localparam logic [15:0] DEST_BIAS    = 16'h01f4;
    localparam logic [15:0] DEST_MIN     = 16'h01f5;
    localparam logic [15:0] DEST_MAX     = 16'h0257;
    localparam logic [15:0] SRC_MIN      = 16'h0001;
    localparam logic [15:0] SRC_MAX      = 16'hfffe;
    localparam logic [15:0] WD_MIN       = 16'h007d;
    localparam logic [15:0] WD_MAX       = 16'h2710;
    localparam logic [15:0] WD_RST       = 16'h007d;

    typedef enum logic [1:0] {
        CLASS_SIL1 = 2'h0,
        CLASS_SIL2 = 2'h1,
        CLASS_SIL3 = 2'h2,
        CLASS_NONE = 2'h3
    } integrity_class_e;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] speed;
        logic [15:0] multi;
        logic [15:0] single;
    } input_image_s;

    typedef struct packed {
        logic [7:0]  opt;
        logic [7:0]  ident;
        logic [15:0] src;
        logic [15:0] dest;
        logic [15:0] wd;
        logic [31:0] device_param_checksum;
        logic [15:0] par_checksum;
    } param_block_s;

endpackage : encoder_image_pkg

// ===== rtl/encoder_process_image.sv
// Encoder cyclic input image, speed integration and safety parameter supervision
module encoder_process_image #(
    parameter int BASE_CYC = encoder_image_pkg::BASE_CYCLES, // Cycles in 5 ms time base
    parameter int MS_CYC   = encoder_image_pkg::MS_CYCLES,   // Cycles in 1 ms
    parameter logic [1:0] LOCAL_CLASS = 2'h2                 // Locally supported class
) (
    input  wire logic                 ref_clk,        // System clock
    input  wire logic                 rst_n,          // Synchronous reset, active low
    input  wire logic [27:0]          raw_pos,        // Absolute position from sensor logic
    input  wire logic                 dir_cfg,        // Counting direction, 1 = increasing
    input  wire logic [6:0]           integ_set,      // Integration setting, 1..100
    input  wire logic [6:0]           station_pins,   // Address switch pins
    input  wire logic [2:0]           img_ofs,        // Image byte offset
    output logic      [7:0]           img_byte_ff,    // Image byte at img_ofs
    output encoder_image_pkg::input_image_s image_ff, // Whole input image
    input  wire logic                 par_wr,         // Parameter byte write strobe
    input  wire logic [3:0]           par_ofs,        // Parameter byte offset
    input  wire logic [7:0]           par_data,       // Parameter byte
    input  wire logic                 par_commit,     // Check and take staged block
    input  wire logic                 tele_ok,        // Valid safety telegram received
    output logic                      par_refused_ff, // Last committed block refused
    output logic      [15:0]          wd_time_ff,     // Accepted watchdog time, ms
    output logic                      safe_state_ff   // Device in safe state
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (BASE_CYC < 2 || MS_CYC < 2) begin : g_bad_timing
        $error("Timing counts must be at least 2");
    end

    typedef enum logic [2:0] {
        ST_SAFE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_RUN   = 3'b100
    } safety_state_e;

    localparam logic signed [27:0] LIM_HI = 28'sh0007fff;
    localparam logic signed [27:0] LIM_LO = -28'sh0008000;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Class rank: none lowest, SIL3 highest
    function automatic logic [1:0] class_rank(input logic [1:0] c);
        unique case (c)
            encoder_image_pkg::CLASS_NONE: class_rank = 2'h0;
            encoder_image_pkg::CLASS_SIL1: class_rank = 2'h1;
            encoder_image_pkg::CLASS_SIL2: class_rank = 2'h2;
            default:                       class_rank = 2'h3;
        endcase
    endfunction

    // Join two staged bytes, high byte first
    function automatic logic [15:0] be16(input logic [7:0] hi, input logic [7:0] lo);
        be16 = {hi, lo};
    endfunction

    // ------------------------------------------------------------------
    // Station address synchroniser
    // ------------------------------------------------------------------
    logic [6:0] stn_s1_ff, stn_s2_ff, stn_s3_ff;
    logic [6:0] station_ff;

    // Pins are asynchronous; only s2 and s3 are compared
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stn_s1_ff  <= 7'h00;
            stn_s2_ff  <= 7'h00;
            stn_s3_ff  <= 7'h00;
            station_ff <= 7'h00;
        end else begin
            stn_s1_ff <= station_pins;
            stn_s2_ff <= stn_s1_ff;
            stn_s3_ff <= stn_s2_ff;
            if (stn_s2_ff == stn_s3_ff) begin
                station_ff <= stn_s3_ff;
            end
        end
    end

    // ------------------------------------------------------------------
    // Position and direction
    // ------------------------------------------------------------------
    logic [27:0] pos_dir;

    // Backward direction mirrors the count so clockwise counts down
    assign pos_dir = dir_cfg ? raw_pos : (~raw_pos + 28'h0000001);

    // ------------------------------------------------------------------
    // Integration period timing
    // ------------------------------------------------------------------
    logic [31:0] base_cnt_ff;
    logic [6:0]  per_cnt_ff;
    logic [6:0]  integ_eff;
    logic        base_tick;
    logic        period_end;

    // Out-of-range settings clamp rather than stall the speed update
    assign integ_eff  = (integ_set < encoder_image_pkg::INTEG_MIN) ? encoder_image_pkg::INTEG_MIN :
                        (integ_set > encoder_image_pkg::INTEG_MAX) ? encoder_image_pkg::INTEG_MAX :
                        integ_set;
    assign base_tick  = (base_cnt_ff == 32'(BASE_CYC - 1));
    assign period_end = base_tick && (per_cnt_ff >= integ_eff - 7'h01);

    // Base counter and period counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            base_cnt_ff <= 32'h0;
            per_cnt_ff  <= 7'h00;
        end else begin
            base_cnt_ff <= base_tick ? 32'h0 : base_cnt_ff + 32'h1;
            if (period_end) begin
                per_cnt_ff <= 7'h00;
            end else if (base_tick) begin
                per_cnt_ff <= per_cnt_ff + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Speed measurement with saturation
    // ------------------------------------------------------------------
    logic [27:0]        prev_pos_ff;
    logic               primed_ff;
    logic signed [27:0] delta;

    // Modular difference handles wrap through zero of the count
    assign delta = $signed(pos_dir - prev_pos_ff);

    // First period only takes a reference, avoiding a false jump at start
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prev_pos_ff <= 28'h0;
            primed_ff   <= 1'b0;
        end else if (period_end) begin
            prev_pos_ff <= pos_dir;
            primed_ff   <= 1'b1;
        end
    end

    // Image words; status bits 15..1 never set
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            image_ff <= '0;
        end else begin
            image_ff.multi  <= {1'b0, pos_dir[27:13]};
            image_ff.single <= {3'h0, pos_dir[12:0]};
            image_ff.status[15:1] <= 15'h0000;
            if (period_end && primed_ff) begin
                if (delta > LIM_HI) begin
                    image_ff.speed <= encoder_image_pkg::SPEED_POS_SAT;
                    image_ff.status[encoder_image_pkg::OVF_BIT] <= 1'b1;
                end else if (delta < LIM_LO) begin
                    image_ff.speed <= encoder_image_pkg::SPEED_NEG_SAT;
                    image_ff.status[encoder_image_pkg::OVF_BIT] <= 1'b1;
                end else begin
                    image_ff.speed <= delta[15:0];
                    image_ff.status[encoder_image_pkg::OVF_BIT] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte read port, high byte at the even offset
    // ------------------------------------------------------------------
    logic [15:0] sel_word;
    always_comb begin
        unique case (img_ofs[2:1])
            2'h0:    sel_word = image_ff.status;
            2'h1:    sel_word = image_ff.speed;
            2'h2:    sel_word = image_ff.multi;
            default: sel_word = image_ff.single;
        endcase
    end

    // Registered byte out
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            img_byte_ff <= 8'h00;
        end else begin
            img_byte_ff <= img_ofs[0] ? sel_word[7:0] : sel_word[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Parameter block staging, big-endian assembly
    // ------------------------------------------------------------------
    logic [7:0] stage_ff [encoder_image_pkg::PAR_BYTES];
    encoder_image_pkg::param_block_s blk;
    // Host bytes land at their block offset; offsets past the block are ignored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < encoder_image_pkg::PAR_BYTES; i++) begin
                stage_ff[i] <= 8'h00;
            end
        end else if (par_wr && (par_ofs < 4'(encoder_image_pkg::PAR_BYTES))) begin
            stage_ff[par_ofs] <= par_data;
        end
    end

    // Fields assembled high byte first
    always_comb begin
        blk.opt   = stage_ff[0];
        blk.ident = stage_ff[1];
        blk.src   = be16(stage_ff[encoder_image_pkg::SRC_OFS],
                         stage_ff[encoder_image_pkg::SRC_OFS + 1]);
        blk.dest  = be16(stage_ff[encoder_image_pkg::DEST_OFS],
                         stage_ff[encoder_image_pkg::DEST_OFS + 1]);
        blk.wd    = be16(stage_ff[encoder_image_pkg::WD_OFS],
                         stage_ff[encoder_image_pkg::WD_OFS + 1]);
        blk.device_param_checksum = {be16(stage_ff[encoder_image_pkg::IPAR_OFS],
                                          stage_ff[encoder_image_pkg::IPAR_OFS + 1]),
                                     be16(stage_ff[encoder_image_pkg::IPAR_OFS + 2],
                                          stage_ff[encoder_image_pkg::IPAR_OFS + 3])};
        blk.par_checksum = be16(stage_ff[encoder_image_pkg::PCRC_OFS],
                                stage_ff[encoder_image_pkg::PCRC_OFS + 1]);
    end

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    logic        ok_seq, ok_class, ok_crclen, ok_blkid, ok_ver, ok_dest, ok_src, ok_wd;
    logic        blk_ok;
    logic [15:0] dest_exp;
    assign dest_exp  = {9'h000, station_ff} + encoder_image_pkg::DEST_BIAS;
    assign ok_seq    = !blk.opt[encoder_image_pkg::SEQ_BIT];
    assign ok_class  = class_rank(blk.opt[encoder_image_pkg::CLASS_LSB +: 2])
                       <= class_rank(LOCAL_CLASS);
    assign ok_crclen = blk.opt[encoder_image_pkg::CRCLEN_LSB +: 2]
                       == encoder_image_pkg::CRCLEN_REQ;
    assign ok_blkid  = blk.ident[encoder_image_pkg::BLKID_LSB +: 3]
                       == encoder_image_pkg::BLKID_REQ;
    assign ok_ver    = blk.ident[encoder_image_pkg::VER_LSB +: 2]
                       == encoder_image_pkg::VER_REQ;
    assign ok_dest   = (blk.dest == dest_exp) && (blk.dest >= encoder_image_pkg::DEST_MIN)
                       && (blk.dest <= encoder_image_pkg::DEST_MAX);
    // Defensive: a host slip on the source address is caught here too
    assign ok_src    = (blk.src >= encoder_image_pkg::SRC_MIN)
                       && (blk.src <= encoder_image_pkg::SRC_MAX) && (blk.src != blk.dest);
    assign ok_wd     = (blk.wd >= encoder_image_pkg::WD_MIN)
                       && (blk.wd <= encoder_image_pkg::WD_MAX);
    assign blk_ok    = ok_seq && ok_class && ok_crclen && ok_blkid && ok_ver
                       && ok_dest && ok_src && ok_wd;

    // ------------------------------------------------------------------
    // Safety state and watchdog
    // ------------------------------------------------------------------
    safety_state_e state_ff;
    logic [31:0]   ms_cnt_ff;
    logic [15:0]   wd_ms_ff;
    logic          ms_tick;
    logic          wd_expired;
    assign ms_tick    = (ms_cnt_ff == 32'(MS_CYC - 1));
    assign wd_expired = (state_ff == ST_RUN) && (wd_ms_ff >= wd_time_ff);
    // Millisecond watchdog, restarted by every valid telegram
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ms_cnt_ff <= 32'h0;
            wd_ms_ff  <= 16'h0000;
        end else if (tele_ok || state_ff != ST_RUN) begin
            ms_cnt_ff <= 32'h0;
            wd_ms_ff  <= 16'h0000;
        end else begin
            ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
            if (ms_tick) begin
                wd_ms_ff <= wd_ms_ff + 16'h0001;
            end
        end
    end

    // Commit wins over telegram; expiry drops to armed so a fresh telegram resumes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff       <= ST_SAFE;
            par_refused_ff <= 1'b0;
            wd_time_ff     <= encoder_image_pkg::WD_RST;
        end else if (par_commit) begin
            par_refused_ff <= !blk_ok;
            if (blk_ok) begin
                state_ff   <= ST_ARMED;
                wd_time_ff <= blk.wd;
            end else begin
                state_ff   <= ST_SAFE;
            end
        end else begin
            unique case (state_ff)
                ST_SAFE:  state_ff <= ST_SAFE;
                ST_ARMED: state_ff <= tele_ok ? ST_RUN : ST_ARMED;
                ST_RUN:   state_ff <= wd_expired ? ST_ARMED : ST_RUN;
            endcase
        end
    end

    // Safe output unless running under a live watchdog with no commit in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            safe_state_ff <= 1'b1;
        end else begin
            safe_state_ff <= !(state_ff == ST_RUN && !wd_expired) || par_commit;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_bad_commit;
        par_commit && !blk_ok;
    endsequence
    sequence s_period_over;
        period_end && primed_ff && (delta > LIM_HI || delta < LIM_LO);
    endsequence
    property p_sat;
        @(posedge ref_clk) disable iff (!rst_n)
        image_ff.status[0] |-> (image_ff.speed == 16'h7fff || image_ff.speed == 16'h8000);
    endproperty
    a_sat: assert property (p_sat) else $error("Overflow without saturated speed");
    property p_ovf_set;
        @(posedge ref_clk) disable iff (!rst_n)
        s_period_over |=> image_ff.status[0];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag not set");
    property p_ovf_clr;
        @(posedge ref_clk) disable iff (!rst_n)
        period_end && primed_ff && delta <= LIM_HI && delta >= LIM_LO
        |=> !image_ff.status[0] && image_ff.speed == $past(delta[15:0]);
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("Speed in range mishandled");
    property p_rsvd;
        @(posedge ref_clk) disable iff (!rst_n)
        image_ff.status[15:1] == 15'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("Reserved status bit set");
    property p_pos;
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 {image_ff.multi[14:0], image_ff.single[12:0]}
            == ($past(dir_cfg) ? $past(raw_pos) : 28'h0 - $past(raw_pos))
            && !image_ff.multi[15];
    endproperty
    a_pos: assert property (p_pos) else $error("Position words mismatch");
    property p_refuse;
        @(posedge ref_clk) disable iff (!rst_n)
        s_bad_commit |=> state_ff == ST_SAFE && par_refused_ff ##1 safe_state_ff;
    endproperty
    a_refuse: assert property (p_refuse) else $error("Bad block not refused");
    property p_seq;
        @(posedge ref_clk) disable iff (!rst_n)
        par_commit && blk.opt[0] |=> state_ff == ST_SAFE;
    endproperty
    a_seq: assert property (p_seq) else $error("Sequence check option accepted");
    property p_wd;
        @(posedge ref_clk) disable iff (!rst_n)
        wd_expired && !par_commit |=> state_ff == ST_ARMED && safe_state_ff;
    endproperty
    a_wd: assert property (p_wd) else $error("Watchdog expiry ignored");
    property p_dest;
        @(posedge ref_clk) disable iff (!rst_n)
        par_commit && blk.dest != {9'h000, station_ff} + 16'h01f4 |=> par_refused_ff;
    endproperty
    a_dest: assert property (p_dest) else $error("Wrong destination accepted");
    property p_byte;
        @(posedge ref_clk) disable iff (!rst_n)
        img_ofs == 3'h2 |=> img_byte_ff == $past(image_ff.speed[15:8]);
    endproperty
    a_byte: assert property (p_byte) else $error("Speed high byte not at offset 2");

endmodule // encoder_process_image
